// file: design/dfs_map.svh
`ifndef DFS_MAP_SVH
`define DFS_MAP_SVH

// register byte offsets
`define DFS_OFF_CTRL      4'h0
`define DFS_OFF_ISTAT     4'h4
`define DFS_OFF_IMASK     4'h8
`define DFS_OFF_RXSTAT    4'hc

// format_switch_control field positions
`define DFS_BIT_SWE       7
`define DFS_BIT_SW        6
`define DFS_BIT_IE        5
`define DFS_BIT_IF        4
`define DFS_CLR_HI        3
`define DFS_CLR_LO        0

// interrupt status bit positions
`define DFS_IRQ_SWITCH    0
`define DFS_IRQ_LATCH_CLEAR_CODE_B0      1
`define DFS_IRQ_LATCH_CLEAR_CODE_B1      2

// latch clear codes
`define DFS_CLR_CH0       4'h5
`define DFS_CLR_CH1       4'h6
`define DFS_CLR_BOTH      4'h7
`define DFS_CLR_READ      4'hf

// reset values
`define DFS_RST_CTRL      1'b0
`define DFS_RST_IRQ       3'h0
`define DFS_RST_SCL       1'b1

`endif

// file: design/dfs_pkg.sv
package dfs_pkg;

    typedef logic [3:0]  dfs_addr_t;
    typedef logic [31:0] dfs_word_t;
    typedef logic [3:0]  dfs_be_t;
    typedef logic [2:0]  dfs_irq_t;
    typedef logic [1:0]  dfs_chan_t;

    typedef enum logic [1:0] {
        DFS_IDLE = 2'b01,
        DFS_ACK  = 2'b10
    } dfs_bus_state_t;

endpackage : dfs_pkg

// file: design/dfs_fall_det.sv
`timescale 1ns/1ps
`include "dfs_map.svh"

module dfs_fall_det (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // serial clock level and its falling edge
    input  wire logic scl,
    output logic      fall
);
    logic scl_prev_q;
    logic scl_prev_d;

    always_comb begin
        scl_prev_d = scl;
        fall       = scl_prev_q & ~scl;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_prev_q <= `DFS_RST_SCL;
        end else begin
            scl_prev_q <= scl_prev_d;
        end
    end

endmodule : dfs_fall_det

// file: design/dfs_format_switch.sv
// Function
// RULE1: auto_switch_enable 1 lets serial clock fall switch channel zero.
// RULE2: formatless_select 1 means formatless mode, 0 standard bus format.
// RULE3: formatless_select sets only on write 1 after reading it as 0.
// RULE4: formatless_select clears on write 0 or enabled clock fall.
// RULE5: switch_irq_enable gates the switch interrupt.
// RULE6: switch flag marks an interrupt request from an automatic switch.
// RULE7: switch flag sets on serial clock fall while switch enabled.
// RULE8: switch flag clears only by write 0 after reading it as 1.
// RULE9: clear code 5 clears channel zero, 6 channel one, 7 both.
// RULE10: software never writes codes 00xx or 0100; 1xxx does nothing.
// RULE11: a valid clear code gives one clear pulse per chosen channel.
// RULE12: clear field is write-only and always reads as all ones.
// RULE13: software writes all four clear bits in one register write.
// RULE14: each further clear needs the full code written again.
// RULE15: software writes ones to the clear field when not clearing.
// RULE16: a latch clear also clears that channel's rx_data_ready_flag.
// RULE17: switch interrupt output is high while flag and enable are 1.
`timescale 1ns/1ps
`include "dfs_map.svh"

module dfs_format_switch (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // avalon-mm slave
    input  dfs_pkg::dfs_addr_t avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  dfs_pkg::dfs_word_t avs_writedata,
    input  dfs_pkg::dfs_be_t   avs_byteenable,
    output dfs_pkg::dfs_word_t avs_readdata,
    output logic            avs_waitrequest,
    // serial clock pin of channel zero
    input  wire logic       scl,
    // receive events of both channels
    input  dfs_pkg::dfs_chan_t rx_done,
    input  dfs_pkg::dfs_chan_t rx_read,
    // channel controls
    output logic            formatless_mode,
    output logic            clr_ch0,
    output logic            clr_ch1,
    output dfs_pkg::dfs_chan_t rx_data_ready_flag,
    // interrupts
    output logic            sw_irq,
    output logic            irq
);
    import dfs_pkg::*;

    dfs_bus_state_t state_q;
    dfs_bus_state_t state_d;
    logic           wait_q;
    logic           wait_d;
    dfs_word_t      rdata_q;
    dfs_word_t      rdata_d;

    logic           swe_q;
    logic           swe_d;
    logic           sw_q;
    logic           sw_d;
    logic           ie_q;
    logic           ie_d;
    logic           if_q;
    logic           if_d;
    logic           sw_rd0_q;
    logic           sw_rd0_d;
    logic           if_rd1_q;
    logic           if_rd1_d;
    logic           sw_irq_q;
    logic           sw_irq_d;

    logic           latch_clear_code_b0_q;
    logic           latch_clear_code_b0_d;
    logic           latch_clear_code_b1_q;
    logic           latch_clear_code_b1_d;
    dfs_chan_t      rxf_q;
    dfs_chan_t      rxf_d;
    dfs_chan_t      clr_vec;

    dfs_irq_t       istat_q;
    dfs_irq_t       istat_d;
    dfs_irq_t       imask_q;
    dfs_irq_t       imask_d;
    dfs_irq_t       ievent;
    logic           irq_q;
    logic           irq_d;

    logic           fall;
    logic           ev_sw;
    logic           acc;
    logic           wr_lo;
    logic           wr_ctrl;
    logic           rd_ctrl;
    logic [3:0]     code;
    logic [7:0]     ctrl_view;
    logic           sw_set_ok;
    logic           if_clr_ok;

    dfs_fall_det u_fall (
        .clk  (clk),
        .rstn (rstn),
        .scl  (scl),
        .fall (fall)
    );

    // ---------------- bus slave ----------------
    // every access: waitrequest drops one cycle after the request appears
    always_comb begin
        state_d = state_q;
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        unique case (state_q)
            DFS_IDLE: begin
                if (avs_read || avs_write) begin
                    state_d = DFS_ACK;
                    wait_d  = 1'b0;
                    if (avs_read) begin
                        unique case (avs_address)
                            `DFS_OFF_CTRL:   rdata_d = {24'h0, ctrl_view};
                            `DFS_OFF_ISTAT:  rdata_d = {29'h0, istat_q};
                            `DFS_OFF_IMASK:  rdata_d = {29'h0, imask_q};
                            `DFS_OFF_RXSTAT: rdata_d = {30'h0, rxf_q};
                            default:         rdata_d = 32'h0;
                        endcase
                    end
                end
            end
            DFS_ACK: begin
                state_d = DFS_IDLE;
            end
            default: begin
                state_d = DFS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= DFS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            state_q <= state_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    always_comb begin
        acc       = (state_q == DFS_ACK);
        wr_lo     = acc && avs_write && avs_byteenable[0];
        wr_ctrl   = wr_lo && (avs_address == `DFS_OFF_CTRL);
        rd_ctrl   = acc && avs_read && (avs_address == `DFS_OFF_CTRL);
        code      = avs_writedata[`DFS_CLR_HI:`DFS_CLR_LO];
        ctrl_view = {swe_q, sw_q, ie_q, if_q, `DFS_CLR_READ}; // RULE12
        ev_sw     = fall && swe_q; // RULE1
        sw_set_ok = wr_ctrl && sw_rd0_q && avs_writedata[`DFS_BIT_SW];
        if_clr_ok = wr_ctrl && if_rd1_q && !avs_writedata[`DFS_BIT_IF];
    end

    // ---------------- format switch control ----------------
    always_comb begin
        swe_d    = swe_q;
        sw_d     = sw_q;
        ie_d     = ie_q;
        if_d     = if_q;
        sw_rd0_d = sw_rd0_q;
        if_rd1_d = if_rd1_q;
        if (rd_ctrl) begin
            sw_rd0_d = !rdata_q[`DFS_BIT_SW];
            if_rd1_d = rdata_q[`DFS_BIT_IF];
        end
        if (wr_ctrl) begin
            swe_d    = avs_writedata[`DFS_BIT_SWE];
            ie_d     = avs_writedata[`DFS_BIT_IE];
            sw_rd0_d = 1'b0;
            if_rd1_d = 1'b0;
            if (!avs_writedata[`DFS_BIT_SW]) begin
                sw_d = 1'b0; // RULE4
            end else if (sw_rd0_q) begin
                sw_d = 1'b1; // RULE3
            end
            if (!avs_writedata[`DFS_BIT_IF] && if_rd1_q) begin
                if_d = 1'b0; // RULE8
            end
        end
        // hardware switch wins over a same-cycle write
        if (ev_sw) begin
            sw_d = 1'b0; // RULE4
            if_d = 1'b1; // RULE7
        end
        sw_irq_d = if_d && ie_d; // RULE17
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            swe_q    <= `DFS_RST_CTRL;
            sw_q     <= `DFS_RST_CTRL;
            ie_q     <= `DFS_RST_CTRL;
            if_q     <= `DFS_RST_CTRL;
            sw_rd0_q <= 1'b0;
            if_rd1_q <= 1'b0;
            sw_irq_q <= 1'b0;
        end else begin
            swe_q    <= swe_d;
            sw_q     <= sw_d;
            ie_q     <= ie_d;
            if_q     <= if_d;
            sw_rd0_q <= sw_rd0_d;
            if_rd1_q <= if_rd1_d;
            sw_irq_q <= sw_irq_d;
        end
    end

    // ---------------- latch clear ----------------
    always_comb begin
        latch_clear_code_b0_d = 1'b0;
        latch_clear_code_b1_d = 1'b0;
        if (wr_ctrl) begin
            unique case (code)
                `DFS_CLR_CH0:  latch_clear_code_b0_d = 1'b1; // RULE9
                `DFS_CLR_CH1:  latch_clear_code_b1_d = 1'b1; // RULE9
                `DFS_CLR_BOTH: begin
                    latch_clear_code_b0_d = 1'b1; // RULE9
                    latch_clear_code_b1_d = 1'b1;
                end
                default: begin
                    latch_clear_code_b0_d = 1'b0;
                    latch_clear_code_b1_d = 1'b0;
                end
            endcase
        end
        clr_vec = {latch_clear_code_b1_d, latch_clear_code_b0_d};
    end

    // receive data ready per channel; a new reception beats a clear
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_rx
            always_comb begin
                rxf_d[ch] = rxf_q[ch];
                if (clr_vec[ch] || rx_read[ch]) begin
                    rxf_d[ch] = 1'b0; // RULE16
                end
                if (rx_done[ch]) begin
                    rxf_d[ch] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch_clear_code_b0_q <= 1'b0;
            latch_clear_code_b1_q <= 1'b0;
            rxf_q  <= 2'h0;
        end else begin
            latch_clear_code_b0_q <= latch_clear_code_b0_d; // RULE11
            latch_clear_code_b1_q <= latch_clear_code_b1_d; // RULE11
            rxf_q  <= rxf_d;
        end
    end

    // ---------------- interrupt status and mask ----------------
    always_comb begin
        ievent = 3'h0;
        ievent[`DFS_IRQ_SWITCH] = ev_sw; // RULE6
        ievent[`DFS_IRQ_LATCH_CLEAR_CODE_B0]   = latch_clear_code_b0_d;
        ievent[`DFS_IRQ_LATCH_CLEAR_CODE_B1]   = latch_clear_code_b1_d;
        istat_d = istat_q;
        imask_d = imask_q;
        if (wr_lo && (avs_address == `DFS_OFF_ISTAT)) begin
            istat_d = istat_q & ~avs_writedata[2:0];
        end
        if (wr_lo && (avs_address == `DFS_OFF_IMASK)) begin
            imask_d = avs_writedata[2:0];
        end
        istat_d = istat_d | ievent;
        irq_d   = |(istat_d & imask_d);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            istat_q <= `DFS_RST_IRQ;
            imask_q <= `DFS_RST_IRQ;
            irq_q   <= 1'b0;
        end else begin
            istat_q <= istat_d;
            imask_q <= imask_d;
            irq_q   <= irq_d;
        end
    end

    assign avs_readdata       = rdata_q;
    assign avs_waitrequest    = wait_q;
    assign formatless_mode    = sw_q; // RULE2
    assign clr_ch0            = latch_clear_code_b0_q;
    assign clr_ch1            = latch_clear_code_b1_q;
    assign rx_data_ready_flag = rxf_q;
    assign sw_irq             = sw_irq_q; // RULE5
    assign irq                = irq_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_auto_clear_sw: assert property ( // RULE4
        fall && swe_q |=> !sw_q
    ) else $error("mode not switched on enabled clock fall");

    chk_no_auto_sw: assert property ( // RULE1
        fall && !swe_q && sw_q && !wr_ctrl |=> sw_q
    ) else $error("mode switched while auto switch disabled");

    chk_sw_set_cause: assert property ( // RULE3
        $rose(sw_q) |-> $past(sw_set_ok)
    ) else $error("mode select set without read-zero then write-one");

    chk_mode_follow: assert property ( // RULE2
        rd_ctrl |-> avs_readdata[`DFS_BIT_SW] == $past(formatless_mode)
    ) else $error("formatless mode output differs from register read");

    chk_flag_set: assert property ( // RULE7
        fall && swe_q |=> if_q && istat_q[`DFS_IRQ_SWITCH]
    ) else $error("switch flag not set on enabled clock fall");

    chk_flag_clear: assert property ( // RULE8
        $fell(if_q) |-> $past(if_clr_ok)
    ) else $error("switch flag cleared without read-one then write-zero");

    chk_swirq_gate: assert property ( // RULE17
        sw_irq == (if_q && ie_q)
    ) else $error("switch interrupt not equal to flag and enable");

    chk_clr_ch0_code: assert property ( // RULE9
        wr_ctrl && code == `DFS_CLR_CH0 |=> clr_ch0 && !clr_ch1
    ) else $error("code five did not clear channel zero only");

    chk_clr_both_code: assert property ( // RULE9
        wr_ctrl && code == `DFS_CLR_BOTH |=> clr_ch0 && clr_ch1
    ) else $error("code seven did not clear both channels");

    chk_clr_pulse_one: assert property ( // RULE11
        clr_ch0 || clr_ch1 |=> !clr_ch0 && !clr_ch1
    ) else $error("clear pulse longer than one cycle");

    chk_clr_read_ones: assert property ( // RULE12
        rd_ctrl |-> avs_readdata[3:0] == 4'hf
    ) else $error("clear field did not read as ones");

    chk_rx_clear: assert property ( // RULE16
        $rose(clr_ch0) && !$past(rx_done[0]) |-> !rx_data_ready_flag[0]
    ) else $error("latch clear left receive flag set");

    chk_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest ##1
        (avs_read || avs_write) |-> !avs_waitrequest ##1 avs_waitrequest
    ) else $error("bus answer not one cycle after request");

    cov_auto_switch: cover property (
        sw_q && swe_q ##1 !sw_q && if_q
    );
    cov_clear_both: cover property (clr_ch0 && clr_ch1);
    cov_irq: cover property ($rose(irq) ##[1:20] $fell(irq));

endmodule : dfs_format_switch

// file: test/testbench.sv
`timescale 1ns/1ps
`include "dfs_map.svh"

module testbench;
    import dfs_pkg::*;

    logic       clk;
    logic       rstn;
    dfs_addr_t  avs_address;
    logic       avs_read;
    logic       avs_write;
    dfs_word_t  avs_writedata;
    dfs_be_t    avs_byteenable;
    dfs_word_t  avs_readdata;
    logic       avs_waitrequest;
    logic       scl;
    dfs_chan_t  rx_done;
    dfs_chan_t  rx_read;
    logic       formatless_mode;
    logic       clr_ch0;
    logic       clr_ch1;
    dfs_chan_t  rx_data_ready_flag;
    logic       sw_irq;
    logic       irq;
    int         n_errors;
    int         comparisons;
    int         cycles;
    int         seed_v;
    dfs_word_t  rd;

    dfs_format_switch dfs_format_switch_i (
        .clk                (clk),
        .rstn               (rstn),
        .avs_address        (avs_address),
        .avs_read           (avs_read),
        .avs_write          (avs_write),
        .avs_writedata      (avs_writedata),
        .avs_byteenable     (avs_byteenable),
        .avs_readdata       (avs_readdata),
        .avs_waitrequest    (avs_waitrequest),
        .scl                (scl),
        .rx_done            (rx_done),
        .rx_read            (rx_read),
        .formatless_mode    (formatless_mode),
        .clr_ch0            (clr_ch0),
        .clr_ch1            (clr_ch1),
        .rx_data_ready_flag (rx_data_ready_flag),
        .sw_irq             (sw_irq),
        .irq                (irq)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic summarize;
        $display("checks %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            $display("[ERR] timeout exp=done got=hang");
            n_errors++;
            summarize();
        end
    end

    task automatic chk_reg(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s exp=%h got=%h", nm, e, g);
            n_errors++;
        end
    endtask : chk_reg

    task automatic chk_bit(input string nm, input logic [1:0] e,
                           input logic [1:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s exp=%b got=%b", nm, e, g);
            n_errors++;
        end
    endtask : chk_bit

    // one access; returns just after the edge that samples waitrequest low
    // a hung slave is caught by the cycle ceiling
    task automatic bus(input logic wr, input dfs_addr_t a,
                       input logic [7:0] d, input dfs_be_t be);
        @(posedge clk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= be;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        #1;
    endtask : bus

    task automatic wr(input dfs_addr_t a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rdc(input dfs_addr_t a);
        bus(1'b0, a, 8'h00, 4'hf);
    endtask : rdc

    // falling serial clock edge, then back high once it has acted
    task automatic scl_fall;
        @(posedge clk);
        scl <= 1'b0;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        #1;
    endtask : scl_fall

    function automatic logic [1:0] exp_clr(input logic [3:0] c);
        return {c == `DFS_CLR_CH1 || c == `DFS_CLR_BOTH,
                c == `DFS_CLR_CH0 || c == `DFS_CLR_BOTH};
    endfunction : exp_clr

    task automatic clr_case(input logic [3:0] c);
        logic [1:0] rv;
        logic [1:0] rr;
        logic [1:0] ex;
        rv = 2'($urandom_range(0, 3));
        rr = 2'($urandom_range(0, 3));
        ex = rv & ~rr & ~exp_clr(c);
        // empty both flags, receive, then read some back
        @(posedge clk);
        rx_read <= 2'b11;
        @(posedge clk);
        rx_read <= 2'b00;
        rx_done <= rv;
        @(posedge clk);
        rx_done <= 2'b00;
        rx_read <= rr;
        @(posedge clk);
        rx_read <= 2'b00;
        wr(`DFS_OFF_CTRL, {4'h2, c});
        chk_bit("clr", exp_clr(c), {clr_ch1, clr_ch0});
        chk_bit("rxflag", ex, rx_data_ready_flag);
        rdc(`DFS_OFF_RXSTAT);
        chk_bit("rxstat", ex, rd[1:0]);
        rdc(`DFS_OFF_ISTAT);
        chk_reg("istat", {5'h0, exp_clr(c), 1'b0}, rd[7:0]);
        wr(`DFS_OFF_ISTAT, 8'h07);
        rdc(`DFS_OFF_CTRL);
        chk_reg("ctrl", 8'h2f, rd[7:0]);
    endtask : clr_case

    initial begin
        rstn = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        scl = 1'b1;
        rx_done = 2'b00;
        rx_read = 2'b00;
        n_errors = 0;
        comparisons = 0;
        cycles = 0;
        seed_v = $urandom(32'h07379002);
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rdc(`DFS_OFF_CTRL);
        chk_reg("ctrl", 8'h0f, rd[7:0]);
        rdc(4'h2);
        chk_reg("unmapped", 8'h00, rd[7:0]);
        $display("test reset done");
        // a control write forgets the earlier read of the select bit
        wr(`DFS_OFF_CTRL, 8'h0f);
        wr(`DFS_OFF_CTRL, 8'h4f);
        chk_bit("mode", 2'b00, {1'b0, formatless_mode});
        rdc(`DFS_OFF_CTRL);
        wr(`DFS_OFF_CTRL, 8'h4f);
        chk_bit("mode", 2'b01, {1'b0, formatless_mode});
        rdc(`DFS_OFF_CTRL);
        chk_reg("ctrl", 8'h4f, rd[7:0]);
        wr(`DFS_OFF_CTRL, 8'h0f);
        chk_bit("mode", 2'b00, {1'b0, formatless_mode});
        $display("test format select done");
        rdc(`DFS_OFF_CTRL);
        wr(`DFS_OFF_CTRL, 8'h6f);
        scl_fall();
        chk_bit("mode", 2'b01, {1'b0, formatless_mode});
        chk_bit("swirq", 2'b00, {1'b0, sw_irq});
        wr(`DFS_OFF_CTRL, 8'hef);
        scl_fall();
        chk_bit("mode", 2'b00, {1'b0, formatless_mode});
        chk_bit("swirq", 2'b01, {1'b0, sw_irq});
        chk_bit("irq", 2'b00, {1'b0, irq});
        rdc(`DFS_OFF_CTRL);
        chk_reg("ctrl", 8'hbf, rd[7:0]);
        $display("test auto switch done");
        rdc(`DFS_OFF_ISTAT);
        chk_reg("istat", 8'h01, rd[7:0]);
        wr(`DFS_OFF_IMASK, 8'h01);
        chk_bit("irq", 2'b01, {1'b0, irq});
        wr(`DFS_OFF_ISTAT, 8'h01);
        chk_bit("irq", 2'b00, {1'b0, irq});
        $display("test interrupt done");
        wr(`DFS_OFF_CTRL, 8'hbf);
        wr(`DFS_OFF_CTRL, 8'h9f);
        chk_bit("swirq", 2'b00, {1'b0, sw_irq});
        rdc(`DFS_OFF_CTRL);
        chk_reg("ctrl", 8'h9f, rd[7:0]);
        wr(`DFS_OFF_CTRL, 8'hbf);
        chk_bit("swirq", 2'b01, {1'b0, sw_irq});
        rdc(`DFS_OFF_CTRL);
        wr(`DFS_OFF_CTRL, 8'haf);
        chk_bit("swirq", 2'b00, {1'b0, sw_irq});
        rdc(`DFS_OFF_CTRL);
        chk_reg("ctrl", 8'haf, rd[7:0]);
        // a write without lane zero must leave the register alone
        bus(1'b1, `DFS_OFF_CTRL, 8'h0f, 4'he);
        rdc(`DFS_OFF_CTRL);
        chk_reg("ctrl_be", 8'haf, rd[7:0]);
        $display("test flag clear done");
        rdc(`DFS_OFF_CTRL);
        // codes 0000..0100 are never written by software
        for (int c = 5; c < 16; c++) begin
            clr_case(4'(c));
        end
        repeat (20) begin
            clr_case(4'($urandom_range(5, 15)));
        end
        $display("test latch clear done");
        summarize();
    end

endmodule : testbench
